// ### src/fault_pin_config.v
/*
 * Dedicated pin functions, enable mode decode, Avalon-MM slave.
 * Assumes event inputs on i_core_clk; pins are async.
 */
`timescale 1ns/1ps
`include "fault_pin_defines.vh"
module fault_pin_config #(
    parameter NUM_MON     = 12,                     // Monitored inputs
    parameter RST_TIMEOUT = `RST_TIMEOUT_CYC        // Reset hold cycles
) (
    input  wire               i_core_clk,           // Core clock, 250 MHz
    input  wire               i_arst_n,             // Async reset, active low
    // Avalon-MM slave
    input  wire [9:0]         i_avs_address,        // Byte address
    input  wire               i_avs_read,           // Read request
    input  wire               i_avs_write,          // Write request
    input  wire [31:0]        i_avs_writedata,      // Write data
    input  wire [3:0]         i_avs_byteenable,     // Byte enables
    output reg  [31:0]        o_avs_readdata,       // Read data
    output wire               o_avs_waitrequest,    // Wait request
    // Comparator flags and system events
    input  wire [NUM_MON-1:0] i_mon_ov,             // Overvoltage crossings
    input  wire [NUM_MON-1:0] i_mon_uv,             // Undervoltage crossings
    input  wire [NUM_MON-1:0] i_mon_ew,             // Early warning crossings
    input  wire               i_powerup_fault,      // Fault during power up/down
    input  wire               i_wdog_expired,       // Watchdog timer expired
    input  wire [2:0]         i_en_on,              // Sequencer enable requests
    // General pins four to six
    input  wire               i_general_pin_four,   // Manual reset input pin
    input  wire               i_general_pin_five,   // Watchdog kick input pin
    input  wire               i_general_pin_six,    // Pin six input level
    output reg                o_general_pin_six,    // Pin six output level
    output reg                o_general_pin_six_oe_n, // Pin six drive, low drives
    // Derived outputs
    output wire               o_watchdog_kick,      // Synchronised kick level
    output reg                o_any_fault,          // Combined fault, frozen
    output reg                o_reset_n,            // Reset output, active low
    output wire               o_override,           // Override in effect
    output wire               o_fault_log_en,       // Fault logging allowed
    output reg                o_fault_save,         // Save fault data pulse
    output wire               o_force_en_low,       // Pull enables low
    // Enable outputs one to three
    output wire [2:0]         o_en_out,             // Enable pin levels
    output wire [2:0]         o_en_oe_n,            // Enable drive, low drives
    output wire [2:0]         o_en_track,           // Tracking mode active
    output wire [2:0]         o_en_pump             // Charge pump active
);
    localparam [31:0] TMO_CYC = RST_TIMEOUT;        // Timeout as 32 bits

    // Registers
    reg  [7:0]  flt2_low_sel_ff;                    // Monitors one to eight
    reg  [7:0]  flt2_high_sel_ff;                   // Monitors nine up, modes
    reg  [7:0]  pin_func_a_ff;                      // Pin five/six function
    reg  [7:0]  pin_func_b_ff;                      // Pin six function high
    reg  [7:0]  en_mode_low_ff;                     // Enable one to three modes
    reg  [7:0]  en_mode_high_ff;                    // Enable three top bit
    reg  [7:0]  override_ctl_ff;                    // Software override
    reg  [7:0]  block_ctl_ff;                       // Manual reset enable
    reg         puf_flag_ff;                        // Sticky power-up fault
    reg         ack_ff;                             // Bus answer cycle
    reg         second_fault_output_ff;                          // Frozen second fault state
    reg         rst_hold_ff;                        // Reset asserted state
    reg  [31:0] tmo_cnt_ff;                         // Reset timeout counter
    reg  [31:0] nxt_tmo_cnt;                        // Next counter value
    reg         nxt_rst_hold;                       // Next reset state
    reg  [7:0]  rd_mux;                             // Read data select

    wire [7:0]  reg_idx  = i_avs_address[9:2];      // Register index
    wire        bus_req  = i_avs_read | i_avs_write;
    wire        wr_stb   = i_avs_write & ack_ff & i_avs_byteenable[0];
    wire [7:0]  wr_byte  = i_avs_writedata[7:0];
    wire [2:0]  pin6_fn  = {pin_func_b_ff[1:0], pin_func_a_ff[`PIN6_FN_LSB_BIT]};
    wire [2:0]  pin5_fn  = pin_func_a_ff[`PIN5_FN_MSB:`PIN5_FN_LSB];
    wire        pin4_s;                             // Synced pin four
    wire        pin5_s;                             // Synced pin five
    wire        pin6_s;                             // Synced pin six

    // One wait state per access
    assign o_avs_waitrequest = bus_req & ~ack_ff;

    // Answer flag toggles once per request
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            ack_ff <= 1'b0;
        else
            ack_ff <= bus_req & ~ack_ff;
    end

    // Pin synchronisers
    pin_sync2 #(.RST_VAL(1'b1)) u_sync_four (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_pin      (i_general_pin_four),
        .o_level    (pin4_s)
    );
    pin_sync2 #(.RST_VAL(1'b1)) u_sync_five (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_pin      (i_general_pin_five),
        .o_level    (pin5_s)
    );
    pin_sync2 #(.RST_VAL(1'b1)) u_sync_six (
        .i_core_clk (i_core_clk),
        .i_arst_n   (i_arst_n),
        .i_pin      (i_general_pin_six),
        .o_level    (pin6_s)
    );

    // Watchdog kick routed only when pin five takes that function
    assign o_watchdog_kick = (pin5_fn == `FN5_WDOG_IN) & pin5_s;

    // Override from low pin or software bit
    assign o_override = ((pin6_fn == `FN6_OVERRIDE_IN) & ~pin6_s)
                      | override_ctl_ff[`OVR_CTL_BIT];
    assign o_fault_log_en = ~o_override;

    // Configuration register writes
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            flt2_low_sel_ff  <= `RST_REG8;
            flt2_high_sel_ff <= `RST_REG8;
            pin_func_a_ff    <= `RST_REG8;
            pin_func_b_ff    <= `RST_REG8;
            en_mode_low_ff   <= `RST_REG8;
            en_mode_high_ff  <= `RST_REG8;
            override_ctl_ff  <= `RST_REG8;
            block_ctl_ff     <= `RST_REG8;
        end
        else if (wr_stb)
        begin
            case (reg_idx)
                `IDX_FLT2_LOW_SEL:  flt2_low_sel_ff  <= wr_byte;
                `IDX_FLT2_HIGH_SEL: flt2_high_sel_ff <= wr_byte;
                `IDX_PIN_FUNC_A:    pin_func_a_ff    <= wr_byte;
                `IDX_PIN_FUNC_B:    pin_func_b_ff    <= wr_byte;
                `IDX_EN_MODE_LOW:   en_mode_low_ff   <= wr_byte;
                `IDX_EN_MODE_HIGH:  en_mode_high_ff  <= wr_byte;
                `IDX_OVERRIDE_CTL:  override_ctl_ff  <= wr_byte;
                `IDX_BLOCK_CTL:     block_ctl_ff     <= wr_byte;
                default:            block_ctl_ff     <= block_ctl_ff;  // Unmapped
            endcase
        end
    end

    // Read data multiplexer
    always @*
    begin
        case (reg_idx)
            `IDX_FLT2_LOW_SEL:  rd_mux = flt2_low_sel_ff;
            `IDX_FLT2_HIGH_SEL: rd_mux = flt2_high_sel_ff;
            `IDX_PIN_FUNC_A:    rd_mux = pin_func_a_ff;
            `IDX_PIN_FUNC_B:    rd_mux = pin_func_b_ff;
            `IDX_EN_MODE_LOW:   rd_mux = en_mode_low_ff;
            `IDX_EN_MODE_HIGH:  rd_mux = en_mode_high_ff;
            `IDX_OVERRIDE_CTL:  rd_mux = override_ctl_ff;
            `IDX_BLOCK_CTL:     rd_mux = block_ctl_ff;
            `IDX_BLOCK_STATUS:  rd_mux = {2'h0, pin6_s, pin5_s, pin4_s,
                                          rst_hold_ff, o_override, puf_flag_ff};
            default:            rd_mux = 8'h00;            // Unmapped reads zero
        endcase
    end

    // Read data registered on the answer edge
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
            o_avs_readdata <= 32'h00000000;
        else if (i_avs_read & ~ack_ff)
            o_avs_readdata <= {24'h000000, rd_mux};
    end

    // Second fault: selected monitors and enabled thresholds
    wire [NUM_MON-1:0] mon_sel;                     // Monitors feeding output
    wire [NUM_MON-1:0] mon_hit;                     // Enabled crossings
    wire               second_fault_output_raw;                  // Asserted, before polarity
    wire               any_raw;                     // Any crossing at all

    generate
        if (NUM_MON > 12)
        begin : g_sel_wide
            assign mon_sel = {{(NUM_MON-12){1'b0}}, flt2_high_sel_ff[3:0],
                              flt2_low_sel_ff};
        end
        else
        begin : g_sel_fit
            wire [11:0] sel12 = {flt2_high_sel_ff[3:0], flt2_low_sel_ff};
            assign mon_sel = sel12[NUM_MON-1:0];
        end
    endgenerate

    assign mon_hit = (i_mon_ov & {NUM_MON{flt2_high_sel_ff[`F2_OV_BIT]}})
                   | (i_mon_uv & {NUM_MON{flt2_high_sel_ff[`F2_UV_BIT]}})
                   | (i_mon_ew & {NUM_MON{flt2_high_sel_ff[`F2_EW_BIT]}});
    assign second_fault_output_raw = |(mon_hit & mon_sel);
    assign any_raw    = |(i_mon_ov | i_mon_uv | i_mon_ew);

    // Fault states follow inputs unless override freezes them
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            second_fault_output_ff   <= 1'b0;
            o_any_fault <= 1'b0;
        end
        else if (!o_override)
        begin
            second_fault_output_ff   <= second_fault_output_raw;
            o_any_fault <= any_raw;
        end
    end

    // Power-up fault: sticky flag, save pulse, enables forced low
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            puf_flag_ff  <= 1'b0;
            o_fault_save <= 1'b0;
        end
        else
        begin
            // Event wins over a write-one clear in the same cycle
            if (i_powerup_fault & ~o_override)
                puf_flag_ff <= 1'b1;
            else if (wr_stb && reg_idx == `IDX_BLOCK_STATUS
                     && wr_byte[`ST_PUF_BIT])
                puf_flag_ff <= 1'b0;
            // Save only on a new fault, never under override
            o_fault_save <= i_powerup_fault & ~puf_flag_ff & ~o_override;
        end
    end

    assign o_force_en_low = puf_flag_ff;

    // Manual reset and timeout
    always @*
    begin
        nxt_rst_hold = rst_hold_ff;
        nxt_tmo_cnt  = tmo_cnt_ff;
        if (o_override)
        begin
            nxt_rst_hold = rst_hold_ff;
            nxt_tmo_cnt  = tmo_cnt_ff;
        end
        else if (block_ctl_ff[`CTL_MR_EN_BIT] & ~pin4_s)
        begin
            nxt_rst_hold = 1'b1;
            nxt_tmo_cnt  = TMO_CYC;
        end
        else if (rst_hold_ff)
        begin
            if (tmo_cnt_ff <= 32'h00000001)
            begin
                nxt_rst_hold = 1'b0;
                nxt_tmo_cnt  = 32'h00000000;
            end
            else
                nxt_tmo_cnt = tmo_cnt_ff - 32'h00000001;
        end
    end

    // Reset output state
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            rst_hold_ff <= 1'b0;
            tmo_cnt_ff  <= 32'h00000000;
            o_reset_n   <= 1'b1;
        end
        else
        begin
            rst_hold_ff <= nxt_rst_hold;
            tmo_cnt_ff  <= nxt_tmo_cnt;
            o_reset_n   <= ~nxt_rst_hold;
        end
    end

    // Pin six function multiplexer
    always @*
    begin
        o_general_pin_six      = 1'b1;
        o_general_pin_six_oe_n = 1'b1;
        case (pin6_fn)
            `FN6_SECOND_FAULT_OUTPUT:
            begin
                // Polarity: zero active low, one active high
                o_general_pin_six      = flt2_high_sel_ff[`F2_POL_BIT]
                                         ? second_fault_output_ff : ~second_fault_output_ff;
                o_general_pin_six_oe_n = 1'b0;
            end
            `FN6_POWERUP_FAULT:
            begin
                // Open-drain sink while the fault flag stands
                o_general_pin_six      = 1'b0;
                o_general_pin_six_oe_n = ~puf_flag_ff;
            end
            `FN6_WDOG_OUT:
            begin
                // Open-drain, low on expiry
                o_general_pin_six      = 1'b0;
                o_general_pin_six_oe_n = ~i_wdog_expired;
            end
            default:
            begin
                // Input functions: pin left undriven
                o_general_pin_six      = 1'b1;
                o_general_pin_six_oe_n = 1'b1;
            end
        endcase
    end

    // Enable output modes one to three
    wire [8:0] en_modes = {en_mode_high_ff[0], en_mode_low_ff[7:6],
                           en_mode_low_ff[5:3],
                           en_mode_low_ff[2:0]};

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi = gi + 1)
        begin : g_en
            en_mode_decode #(
                .TRACK_OK (1),
                .PUMP_OK  (1)
            ) u_dec (
                .i_mode  (en_modes[gi*3 +: 3]),
                .i_on    (i_en_on[gi] & ~puf_flag_ff),
                .o_out   (o_en_out[gi]),
                .o_oe_n  (o_en_oe_n[gi]),
                .o_track (o_en_track[gi]),
                .o_pump  (o_en_pump[gi])
            );
        end
    endgenerate
endmodule // fault_pin_config

// ### src/fault_pin_defines.vh
// Functional notes
// - High select bits add monitors nine to twelve
// - Bit 4 selects overvoltage crossings
// - Bit 5 selects undervoltage crossings
// - Bit 6 selects early warning crossings
// - Bit 7 picks fault output polarity
// - Selected monitors combine as logical OR
// - Power-up fault: indicate, pull enables, save
// - Override from low pin or control bit
// - Override freezes fault and reset outputs
// - Override ignores thresholds, blocks fault logging
// - Low manual reset input asserts reset
// - Reset held for timeout after release
// - Pin six code 110 is watchdog output
// - Pin five code 111 is watchdog input
// - Watchdog output open-drain, asserted low
// - Enable one three-bit mode decoding
// - Enable two mode from bits 5:3
// - Enable three low bits from 7:6
// - Enable three top bit from next register
// - Tracking outputs one-four, pump one-six only
/*
 * Constants: register indices, fields, codes, resets, timing.
 * Assumes includers use them as plain macros.
 */
`ifndef FAULT_PIN_DEFINES_VH
`define FAULT_PIN_DEFINES_VH

// Register indices (byte address is four times the index)
`define IDX_FLT2_LOW_SEL   8'h17
`define IDX_FLT2_HIGH_SEL  8'h18
`define IDX_PIN_FUNC_A     8'h1D
`define IDX_PIN_FUNC_B     8'h1E
`define IDX_EN_MODE_LOW    8'h1F
`define IDX_EN_MODE_HIGH   8'h20
`define IDX_OVERRIDE_CTL   8'h4D
`define IDX_BLOCK_CTL      8'h60
`define IDX_BLOCK_STATUS   8'h61

// Reset values
`define RST_REG8           8'h00

// Fields of the second fault high select register
`define F2_MON_HI_LSB      0
`define F2_OV_BIT          4
`define F2_UV_BIT          5
`define F2_EW_BIT          6
`define F2_POL_BIT         7

// Pin function, control and status fields
`define PIN6_FN_LSB_BIT    7
`define PIN5_FN_MSB        6
`define PIN5_FN_LSB        4
`define OVR_CTL_BIT        1
`define CTL_MR_EN_BIT      0
`define ST_PUF_BIT         0

// Pin function codes
`define FN6_SECOND_FAULT_OUTPUT         3'h2
`define FN6_POWERUP_FAULT  3'h4
`define FN6_OVERRIDE_IN    3'h5
`define FN6_WDOG_OUT       3'h6
`define FN5_WDOG_IN        3'h7

// Enable output mode codes
`define ENM_OD_LOW         3'h0
`define ENM_OD_HIGH        3'h1
`define ENM_PP_LOW         3'h2
`define ENM_PP_HIGH        3'h3
`define ENM_TRACK          3'h4
`define ENM_PUMP           3'h5

// Timing
`define CLK_PERIOD_NS      4
`define RST_TIMEOUT_NS     25000
`define RST_TIMEOUT_CYC    ((`RST_TIMEOUT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### src/pin_sync2.v
/*
 * Two-stage synchroniser for one pin level.
 * Assumes an asynchronous pin and a free-running core clock.
 */
`timescale 1ns/1ps
module pin_sync2 #(
    parameter RST_VAL = 1'b1                // Level held during reset
) (
    input  wire i_core_clk,                 // Core clock
    input  wire i_arst_n,                   // Async reset, active low
    input  wire i_pin,                      // Raw pin level
    output wire o_level                     // Synchronised level
);
    reg meta_ff;                            // First stage, read by second only
    reg sync_ff;                            // Second stage

    // Two flops in series
    always @(posedge i_core_clk or negedge i_arst_n)
    begin
        if (!i_arst_n)
        begin
            meta_ff <= RST_VAL;
            sync_ff <= RST_VAL;
        end
        else
        begin
            meta_ff <= i_pin;
            sync_ff <= meta_ff;
        end
    end

    assign o_level = sync_ff;
endmodule // pin_sync2

// ### src/en_mode_decode.v
/*
 * Enable output mode decoder.
 * Assumes a same-clock on request.
 */
`timescale 1ns/1ps
`include "fault_pin_defines.vh"
module en_mode_decode #(
    parameter TRACK_OK = 1,                 // Tracking mode accepted
    parameter PUMP_OK  = 1                  // Charge pump mode accepted
) (
    input  wire [2:0] i_mode,               // Mode code
    input  wire       i_on,                 // Sequencer wants output on
    output reg        o_out,                // Pin output level
    output reg        o_oe_n,               // Pin drive enable, low drives
    output reg        o_track,              // Tracking driver selected
    output reg        o_pump                // Charge pump selected
);
    // Mode decode
    always @*
    begin
        o_out   = 1'b0;
        o_oe_n  = 1'b1;
        o_track = 1'b0;
        o_pump  = 1'b0;
        case (i_mode)
            `ENM_OD_LOW:  o_oe_n = ~i_on;               // Sink when on
            `ENM_OD_HIGH: o_oe_n = i_on;                // Sink when off
            `ENM_PP_LOW:
            begin
                o_out  = ~i_on;
                o_oe_n = 1'b0;
            end
            `ENM_PP_HIGH:
            begin
                o_out  = i_on;
                o_oe_n = 1'b0;
            end
            `ENM_TRACK:   o_track = (TRACK_OK != 0);
            `ENM_PUMP:    o_pump  = (PUMP_OK != 0);
            default:      o_oe_n = 1'b1;
        endcase
    end
endmodule // en_mode_decode

// ### test/host_pins.sv
/* Host side of general pin six: pull-up plus a host that may pull it low.
   Assumes the device's drive enable is active low. */
`timescale 1ns/1ps
module host_pins (
    input  wire i_pin6_out,  // Device pin six level
    input  wire i_pin6_oe_n, // Device drive, low drives
    input  wire i_host_low,  // Host pulls the override line low
    output wire o_pin6       // Resolved pin six level
);
    // Device drive wins, then the host, then the pull-up
    assign o_pin6 = !i_pin6_oe_n ? i_pin6_out : !i_host_low;
endmodule // host_pins

// ### test/fault_pin_properties.sv
/* Port checker for fault_pin_config.
   Assumes a bind that hands on the design's ports and parameters. */
`timescale 1ns/1ps
module fault_pin_properties #(
    parameter NUM_MON     = 12, // Monitored inputs
    parameter RST_TIMEOUT = 8   // Reset hold cycles
) (
    input wire               i_core_clk,         // Clock
    input wire               i_arst_n,           // Reset
    input wire               i_avs_read,         // Read
    input wire               i_avs_write,        // Write
    input wire               o_avs_waitrequest,  // Wait
    input wire [NUM_MON-1:0] i_mon_ov,           // Overvoltage
    input wire [NUM_MON-1:0] i_mon_uv,           // Undervoltage
    input wire [NUM_MON-1:0] i_mon_ew,           // Early warning
    input wire               i_powerup_fault,    // Power-up fault
    input wire               i_general_pin_five, // Kick pin
    input wire               o_watchdog_kick,    // Kick level
    input wire               o_any_fault,        // Combined fault
    input wire               o_reset_n,          // Reset out
    input wire               o_override,         // Override
    input wire               o_fault_save,       // Save pulse
    input wire               o_force_en_low      // Enables low
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);
    wire       hit = |(i_mon_ov | i_mon_uv | i_mon_ew); // Any crossing
    reg [15:0] low_cnt_ff;                              // Reset low cycles
    // Counts cycles of reset output low
    always @(posedge i_core_clk or negedge i_arst_n)
        if (!i_arst_n)
            low_cnt_ff <= 16'h0000;
        else
            low_cnt_ff <= o_reset_n ? 16'h0000 : low_cnt_ff + 16'h0001;
    sequence one_wait;
        o_avs_waitrequest ##1 !o_avs_waitrequest;
    endsequence
    sequence save_once;
        o_force_en_low ##1 !o_fault_save;
    endsequence
    bus_wait_a: assert property ($rose(i_avs_read | i_avs_write) |-> one_wait)
        else $error("bus wait state");
    fault_set_a: assert property (!o_override && hit |=> o_any_fault)
        else $error("fault not set");
    fault_clear_a: assert property (!o_override && !hit |=> !o_any_fault)
        else $error("fault not clear");
    freeze_fault_a: assert property (o_override |=> $stable(o_any_fault))
        else $error("fault not frozen");
    freeze_reset_a: assert property (o_override |=> $stable(o_reset_n))
        else $error("reset not frozen");
    save_block_a: assert property (o_override |=> !o_fault_save)
        else $error("save under override");
    puf_set_a: assert property (i_powerup_fault && !o_override |=> o_force_en_low)
        else $error("enables not pulled");
    save_pulse_a: assert property (o_fault_save |-> save_once)
        else $error("save pulse shape");
    reset_hold_a: assert property ($rose(o_reset_n) |-> low_cnt_ff >= RST_TIMEOUT)
        else $error("reset too short");
    kick_sync_a: assert property (o_watchdog_kick |-> $past(i_general_pin_five, 2))
        else $error("kick wrong");
endmodule // fault_pin_properties

// ### test/tb_top.sv
/* Self-checking bench for fault_pin_config with host pin model.
   Assumes design, checker and host model are compiled first. */
`timescale 1ns/1ps
module tb_top;
    logic i_core_clk = 1'b0, i_arst_n = 1'b0, i_avs_read = 1'b0, i_avs_write = 1'b0;
    logic i_powerup_fault = 1'b0, i_wdog_expired = 1'b0, host_low = 1'b0, on, f, h, a;
    logic i_general_pin_four = 1'b1, i_general_pin_five = 1'b1;
    logic [9:0] i_avs_address = 10'h000;
    logic [3:0] i_avs_byteenable = 4'hF;
    logic [2:0] i_en_on = 3'h0;
    logic [11:0] i_mon_ov = 12'h000, i_mon_uv = 12'h000, i_mon_ew = 12'h000;
    logic [31:0] i_avs_writedata = 32'h0, seed = 32'hE769F754, r, s;
    wire [31:0] o_avs_readdata;
    wire [2:0] o_en_out, o_en_oe_n, o_en_track, o_en_pump;
    wire o_avs_waitrequest, o_watchdog_kick, o_any_fault, o_reset_n, o_override, o_fault_log_en;
    wire o_fault_save, o_force_en_low, o_general_pin_six, o_general_pin_six_oe_n, i_general_pin_six;
    int fails = 0, samples_checked = 0, mdl[int], m, k, n;
    fault_pin_config #(.RST_TIMEOUT(8)) fault_pin_config_i (.*);
    host_pins host_pins_i (.i_pin6_out(o_general_pin_six), .i_pin6_oe_n(o_general_pin_six_oe_n),
        .i_host_low(host_low), .o_pin6(i_general_pin_six));
    always #2 i_core_clk = ~i_core_clk;
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task wrap_up();
        if (fails == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task tick(input int c);
        repeat (c) @(posedge i_core_clk);
    endtask
    // One Avalon transfer, held until waitrequest is seen low
    task bus(input logic w, input int i, input int d, input logic [3:0] b);
        i_avs_address <= {i[7:0], 2'b00};
        i_avs_writedata <= {24'h000000, d[7:0]};
        i_avs_byteenable <= b;
        i_avs_read <= !w;
        i_avs_write <= w;
        do @(posedge i_core_clk); while (o_avs_waitrequest);
        i_avs_read <= 1'b0;
        i_avs_write <= 1'b0;
        tick(1);
    endtask
    task put(input int i, input int d);
        bus(1'b1, i, d, 4'hF);
        mdl[i] = d & 255;
    endtask
    task get(input int i);
        bus(1'b0, i, 0, 4'hF);
        check(o_avs_readdata, mdl.exists(i) ? mdl[i] : 0);
    endtask
    initial
    begin
        tick(20);
        i_arst_n <= 1'b1;
        tick(1);
        get(8'h18);
        get(8'h1F);
        r = rnd();
        put(8'h18, r[7:0]);
        bus(1'b1, 8'h18, 8'h5A, 4'h0);
        get(8'h18);
        bus(1'b1, 8'h3F, 8'hFF, 4'hF);
        get(8'h3F);
        // Pin six as second fault output, random selections
        put(8'h1E, 1);
        put(8'h1D, 0);
        repeat (24)
        begin
            s = rnd();
            r = rnd();
            put(8'h17, s[7:0]);
            put(8'h18, s[15:8]);
            i_mon_ov <= 12'h001 << r[3:0];
            i_mon_uv <= 12'h001 << r[7:4];
            i_mon_ew <= 12'h001 << r[11:8];
            tick(2);
            f = |({s[11:8], s[7:0]} & ((i_mon_ov & {12{s[12]}}) | (i_mon_uv & {12{s[13]}})
                | (i_mon_ew & {12{s[14]}})));
            check(i_general_pin_six, s[15] ? f : !f);
            check(o_any_fault, |(i_mon_ov | i_mon_uv | i_mon_ew));
        end
        // Override by register bit freezes outputs
        put(8'h4D, 2);
        h = i_general_pin_six;
        a = o_any_fault;
        i_mon_ov <= ~i_mon_ov;
        tick(3);
        check({i_general_pin_six, o_any_fault}, {h, a});
        check({o_override, o_fault_log_en}, 2'b10);
        put(8'h4D, 0);
        tick(1);
        check(o_any_fault, |(i_mon_ov | i_mon_uv | i_mon_ew));
        // Override by pin six input
        put(8'h1E, 2);
        put(8'h1D, 8'h80);
        host_low <= 1'b1;
        tick(4);
        check(o_override, 1);
        host_low <= 1'b0;
        tick(4);
        check(o_override, 0);
        // Power-up fault indicator
        put(8'h1D, 0);
        i_powerup_fault <= 1'b1;
        tick(1);
        i_powerup_fault <= 1'b0;
        tick(1);
        check({o_fault_save, o_force_en_low, i_general_pin_six, o_general_pin_six_oe_n}, 4'hC);
        bus(1'b1, 8'h61, 1, 4'hF);
        check({o_force_en_low, i_general_pin_six}, 2'b01);
        // Watchdog output and kick input
        put(8'h1E, 3);
        put(8'h1D, 8'h70);
        i_wdog_expired <= 1'b1;
        tick(2);
        check({i_general_pin_six, o_general_pin_six_oe_n}, 2'b00);
        i_wdog_expired <= 1'b0;
        i_general_pin_five <= 1'b0;
        tick(3);
        check({i_general_pin_six, o_general_pin_six_oe_n, o_watchdog_kick}, 3'b110);
        i_general_pin_five <= 1'b1;
        tick(3);
        check(o_watchdog_kick, 1);
        // Manual reset and hold time
        put(8'h60, 1);
        i_general_pin_four <= 1'b0;
        tick(4);
        check(o_reset_n, 0);
        i_general_pin_four <= 1'b1;
        n = 0;
        while (o_reset_n !== 1'b1 && n < 40)
        begin
            tick(1);
            n++;
        end
        check(n >= 8 && n <= 13, 1);
        // Every enable mode code on outputs one to three
        for (m = 0; m < 8; m++)
        begin
            r = rnd();
            put(8'h1F, {m[1:0], m[2:0], m[2:0]});
            put(8'h20, m[2]);
            i_en_on <= r[2:0];
            tick(1);
            for (k = 0; k < 3; k++)
            begin
                on = r[k];
                h = m > 5 || (m < 2 && (on ^ (m == 0)));
                check({o_en_track[k], o_en_pump[k]}, {m == 4, m == 5});
                if (m != 4 && m != 5)
                    check({o_en_oe_n[k], h ? 1'b0 : o_en_out[k]}, {h, m == 3 ? on : m == 2 && !on});
            end
        end
        wrap_up();
    end
    initial
    begin
        #200000;
        fails++;
        wrap_up();
    end
endmodule // tb_top
bind fault_pin_config fault_pin_properties #(.NUM_MON(NUM_MON), .RST_TIMEOUT(RST_TIMEOUT))
    fault_pin_properties_i (.*);
